/* File: rtl/apo_adc_port.sv */
// top of the adc parallel output port: pin sync, encoding, latency
// pipeline, tri-state outputs, avalon-mm registers and interrupt
// assumes converter pins are asynchronous to clk; reset is synchronous
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module apo_adc_port
    import apo_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_CYC
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset,
    // avalon-mm slave
    input  wire logic [AW-1:0]           avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [31:0]             avs_writedata,
    output logic      [31:0]             avs_readdata,
    output logic                         avs_waitrequest,
    // interrupt
    output logic                         irq,
    // converter pins
    input  wire logic                    clock_pos_in,
    input  wire logic                    clock_neg_in,
    input  wire logic signed [ANA_W-1:0] analog_in,
    // sample outputs with enables
    output logic      [SAMPLE_W-1:0]     sample_word,
    output logic                         sample_word_oe,
    output logic                         out_of_range_flag,
    output logic                         out_of_range_oe,
    output logic                         sample_valid_strobe,
    output logic                         sample_valid_oe
);
    localparam int SCW = $clog2(SETTLE_CYCLES + 1);
    localparam int RW  = SAMPLE_W + 1;

    // register-map address match
    function automatic logic hit(input logic [AW-1:0] a,
                                 input logic [AW-1:0] off);
        return a == off;
    endfunction

    // ---------------- pin synchronisers
    logic                    pos_s1, pos_s2, neg_s1, neg_s2;
    logic signed [ANA_W-1:0] ana_s1, ana_s2;
    logic                    lvl_reg;

    // two flops on every pin before use
    always_ff @(posedge clk) begin
        if (reset) begin
            pos_s1 <= 1'b0;
            pos_s2 <= 1'b0;
            neg_s1 <= 1'b0;
            neg_s2 <= 1'b0;
            ana_s1 <= '0;
            ana_s2 <= '0;
        end else begin
            pos_s1 <= clock_pos_in;
            pos_s2 <= pos_s1;
            neg_s1 <= clock_neg_in;
            neg_s2 <= neg_s1;
            ana_s1 <= analog_in;
            ana_s2 <= ana_s1;
        end
    end

    // ---------------- control register fields
    logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
    wire sleep  = ctrl_reg[C_SLEEP];
    wire gray   = ctrl_reg[C_GRAY];
    wire dce_en = ctrl_reg[C_DCE];
    wire ctype  = ctrl_reg[C_CTYPE];

    // converter clock level: single-ended or differential
    wire lvl = ctype ? (pos_s2 & ~neg_s2) : pos_s2;

    apo_edge_if ce ();
    assign ce.level = lvl;
    assign ce.rise  = lvl & ~lvl_reg;
    assign ce.fall  = ~lvl & lvl_reg;

    always_ff @(posedge clk) begin
        if (reset)
            lvl_reg <= 1'b0;
        else
            lvl_reg <= lvl;
    end

    // ---------------- sampler and encoder
    wire over = (ana_s2 > FS_MAX) || (ana_s2 < FS_MIN);
    wire signed [ANA_W-1:0] clamped = (ana_s2 > FS_MAX) ? FS_MAX :
                                      (ana_s2 < FS_MIN) ? FS_MIN : ana_s2;
    wire [SAMPLE_W-1:0] tc_word = clamped[SAMPLE_MSB:SAMPLE_LSB];
    wire [SAMPLE_W-1:0] enc = gray ? apo_to_gray(tc_word)
                                   : tc_word;
    logic [RW-1:0] samp_reg, tail;

    // take the input on the converter falling edge
    always_ff @(posedge clk) begin
        if (reset)
            samp_reg <= '0;
        else if (ce.fall)
            samp_reg <= {over, enc};
    end

    apo_latency_pipe #(
        .W     (RW),
        .DEPTH (PIPE_STAGES)
    ) u_pipe (
        .clk   (clk),
        .reset (reset),
        .e     (ce),
        .din   (samp_reg),
        .dout  (tail)
    );

    apo_duty_equalizer #(
        .CW     (PER_W)
    ) u_dce (
        .clk    (clk),
        .reset  (reset),
        .dce_en (dce_en),
        .e      (ce),
        .strobe (sample_valid_strobe)
    );

    // ---------------- output stage, loads on converter rise
    always_ff @(posedge clk) begin
        if (reset) begin
            sample_word       <= '0;
            out_of_range_flag <= 1'b0;
        end else if (ce.rise) begin
            sample_word       <= tail[SAMPLE_W-1:0];
            out_of_range_flag <= tail[D_OOR];
        end
    end

    // drivers off in power-down
    always_ff @(posedge clk) begin
        if (reset) begin
            sample_word_oe  <= 1'b0;
            out_of_range_oe <= 1'b0;
            sample_valid_oe <= 1'b0;
        end else begin
            sample_word_oe  <= ~sleep;
            out_of_range_oe <= ~sleep;
            sample_valid_oe <= ~sleep;
        end
    end

    // ---------------- reference settling timer after wake
    logic [SCW-1:0] set_cnt_reg;
    logic           settled_reg;
    wire            set_done = set_cnt_reg == SCW'(SETTLE_CYCLES);

    always_ff @(posedge clk) begin
        if (reset || sleep) begin
            set_cnt_reg <= '0;
            settled_reg <= 1'b0;
        end else if (!set_done) begin
            set_cnt_reg <= set_cnt_reg + SCW'(1);
        end else begin
            settled_reg <= 1'b1;
        end
    end

    // ---------------- avalon-mm slave
    apo_bus_e          st_reg, st_next;
    logic [EV_W-1:0]   stat_reg, stat_next, mask_reg, ev, rd_clr;
    logic [31:0]       rd_mux;
    wire req   = avs_read | avs_write;
    wire ans   = st_reg == BUS_ANS;
    wire wr_ok = ans & avs_write;
    wire rd_ok = ans & avs_read;

    // one wait cycle, then answer
    always_comb begin
        case (st_reg)
            BUS_IDLE: st_next = req ? BUS_ANS : BUS_IDLE;
            BUS_ANS:  st_next = BUS_IDLE;
            default:  st_next = BUS_IDLE;
        endcase
    end

    // read data selection; unmapped reads as zero
    assign rd_mux =
        hit(avs_address, OFF_CTRL) ? 32'(ctrl_reg) :
        hit(avs_address, OFF_STAT) ? 32'(stat_reg) :
        hit(avs_address, OFF_MASK) ? 32'(mask_reg) :
        hit(avs_address, OFF_DATA) ? (32'(sample_word)
            | (32'(out_of_range_flag) << D_OOR)
            | (32'(settled_reg) << D_SETTLED)) : 32'h0000_0000;

    // events, clear only what the answered read returned; set wins
    assign ev[S_SAMPLE]  = ce.rise;
    assign ev[S_OOR]     = ce.rise & tail[D_OOR];
    assign ev[S_SETTLED] = set_done & ~settled_reg & ~sleep;
    assign rd_clr = (rd_ok && hit(avs_address, OFF_STAT))
                    ? avs_readdata[EV_W-1:0] : '0;
    assign stat_next = (stat_reg & ~rd_clr) | ev;
    assign ctrl_next = (wr_ok && hit(avs_address, OFF_CTRL))
                       ? avs_writedata[CTRL_W-1:0] : ctrl_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            st_reg          <= BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= '0;
        end else begin
            st_reg          <= st_next;
            avs_waitrequest <= st_next != BUS_ANS;
            if (st_reg == BUS_IDLE && req)
                avs_readdata <= avs_read ? rd_mux : '0;
        end
    end

    // control, status, mask and interrupt
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_reg <= CTRL_RST;
            stat_reg <= '0;
            mask_reg <= '0;
            irq      <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            stat_reg <= stat_next;
            if (wr_ok && hit(avs_address, OFF_MASK))
                mask_reg <= avs_writedata[EV_W-1:0];
            irq <= |(stat_next & mask_reg);
        end
    end

    // ---------------- checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_oor;
        ce.fall |=> samp_reg[D_OOR] == $past(over);
    endproperty
    a_oor: assert property (p_oor) else $error("flag wrong");

    property p_tc;
        ce.fall && !gray |=> samp_reg[SAMPLE_W-1:0] == $past(tc_word);
    endproperty
    a_tc: assert property (p_tc) else $error("twos word wrong");

    property p_gray;
        ce.fall && gray |=>
            samp_reg[SAMPLE_W-1:0] == apo_to_gray($past(tc_word));
    endproperty
    a_gray: assert property (p_gray) else $error("gray word wrong");

    property p_follow;
        !dce_en && !$past(dce_en) |=> sample_valid_strobe == !$past(lvl);
    endproperty
    a_follow: assert property (p_follow) else $error("strobe off clock");

    property p_sleep;
        sleep |=> !sample_word_oe && !out_of_range_oe && !sample_valid_oe;
    endproperty
    a_sleep: assert property (p_sleep) else $error("driven in sleep");

    property p_wake;
        !sleep |=> sample_word_oe && out_of_range_oe && sample_valid_oe;
    endproperty
    a_wake: assert property (p_wake) else $error("not driven awake");

    property p_ctype;
        ctype |-> lvl == (pos_s2 && !neg_s2);
    endproperty
    a_ctype: assert property (p_ctype) else $error("diff clock wrong");

    property p_hold;
        !ce.fall |=> $stable(samp_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("sample off fall");

    property p_pair;
        ce.rise |=> {out_of_range_flag, sample_word} == $past(tail)
                    ##1 $stable(sample_word) && $stable(out_of_range_flag);
    endproperty
    a_pair: assert property (p_pair) else $error("flag unpaired");

    property p_ans;
        req && avs_waitrequest |-> ##[1:2] !avs_waitrequest;
    endproperty
    a_ans: assert property (p_ans) else $error("bus stalled");

    c_oor: cover property (ce.rise ##1 out_of_range_flag);
    c_gray: cover property (gray && ce.fall);
    c_sleep: cover property ($fell(sleep) ##[1:20] sample_word_oe);
    c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

/* File: common/apo_pkg.sv */
// constants, types and helpers for the adc parallel output port
// assumes a 100 mhz system clock and a 12-bit converter core
package apo_pkg;
    // sample word layout
    localparam int SAMPLE_W   = 12;
    localparam int SAMPLE_MSB = 11;
    localparam int SAMPLE_LSB = 0;
    localparam int ANA_W      = 14;
    localparam logic signed [13:0] FS_MAX = 14'sh07ff;
    localparam logic signed [13:0] FS_MIN = 14'sh3800;
    // latency: 8.5 converter cycles counted in half cycles
    localparam int LAT_HALF    = 17;
    localparam int PIPE_STAGES = LAT_HALF - 1; // one stage is the sampler
    localparam int PER_W       = 8;
    // reference settling after wake
    localparam int CLK_MHZ    = 100;
    localparam int SETTLE_MS  = 10;
    localparam int SETTLE_CYC = SETTLE_MS * 1000 * CLK_MHZ;
    // register map, byte addresses
    localparam int AW = 5;
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_STAT = 5'h04;
    localparam logic [4:0] OFF_MASK = 5'h08;
    localparam logic [4:0] OFF_DATA = 5'h0c;
    // control bits
    localparam int C_SLEEP = 0;
    localparam int C_GRAY  = 1;
    localparam int C_DCE   = 2;
    localparam int C_CTYPE = 3;
    localparam int CTRL_W  = 4;
    localparam logic [3:0] CTRL_RST = 4'h4;
    // event bits, shared by status and mask
    localparam int S_SAMPLE  = 0;
    localparam int S_OOR     = 1;
    localparam int S_SETTLED = 2;
    localparam int EV_W      = 3;
    // data readback fields
    localparam int D_OOR     = 12;
    localparam int D_SETTLED = 16;
    // bus answer states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ANS  = 2'b10
    } apo_bus_e;
    // two's complement to gray via offset binary
    function automatic logic [11:0] apo_to_gray(input logic [11:0] tc);
        logic [11:0] ob;
        ob = {~tc[SAMPLE_MSB], tc[SAMPLE_MSB-1:SAMPLE_LSB]};
        return ob ^ (ob >> 1);
    endfunction
endpackage

/* File: common/apo_edge_if.sv */
// converter clock level and its edges as seen in the system clock
// assumes the driver derives them from synchronised pins
`timescale 1ns/1ns
`default_nettype none
interface apo_edge_if;
    logic level;
    logic rise;
    logic fall;
    modport src (output level, output rise, output fall);
    modport snk (input level, input rise, input fall);
endinterface
`default_nettype wire

/* File: rtl/apo_latency_pipe.sv */
// half-cycle delay line for sample words
// assumes rise and fall are one-cycle pulses in the clk domain
`timescale 1ns/1ns
`default_nettype none
module apo_latency_pipe
    import apo_pkg::*;
#(
    parameter int W     = 13,
    parameter int DEPTH = PIPE_STAGES
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // converter edges
    apo_edge_if.snk           e,
    // data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] st [DEPTH];
    wire          adv = e.rise | e.fall;

    // one stage per converter half cycle
    for (genvar i = 0; i < DEPTH; i++) begin : g_st
        always_ff @(posedge clk) begin
            if (reset)
                st[i] <= '0;
            else if (adv)
                st[i] <= (i == 0) ? din : st[(i == 0) ? 0 : i - 1];
        end
    end
    assign dout = st[DEPTH-1];

    property p_shift;
        @(posedge clk) disable iff (reset)
        adv |=> dout == $past(st[DEPTH-2]);
    endproperty
    a_shift: assert property (p_shift) else $error("pipe tail slipped");
endmodule
`default_nettype wire

/* File: rtl/apo_duty_equalizer.sv */
// data-valid strobe generator with optional duty-cycle equaliser
// assumes edges come from the synchronised converter clock
`timescale 1ns/1ns
`default_nettype none
module apo_duty_equalizer
    import apo_pkg::*;
#(
    parameter int CW = PER_W
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // control
    input  wire logic dce_en,
    // converter edges
    apo_edge_if.snk   e,
    // strobe
    output logic      strobe
);
    logic [CW-1:0] cnt_reg, cnt_next, per_reg, hcnt_reg, hcnt_next;
    logic          strobe_next;
    wire  [CW-1:0] half = per_reg >> 1;
    wire  [CW-1:0] cnt_inc = cnt_reg + CW'(1);
    wire  [CW-1:0] hcnt_inc = hcnt_reg + CW'(1);
    wire           sat = &cnt_reg;
    wire           hi_done = strobe && (hcnt_inc >= half);

    // period counter and high-phase counter
    assign cnt_next  = e.fall ? '0 : (sat ? cnt_reg : cnt_inc);
    assign hcnt_next = e.fall ? '0 : (sat ? hcnt_reg : hcnt_inc);
    // equalised: high for half a period from each fall; else the inverted clock
    assign strobe_next = dce_en ? (e.fall | (strobe & ~hi_done))
                                : ~e.level;

    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_reg  <= '0;
            hcnt_reg <= '0;
            per_reg  <= '0;
            strobe   <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            hcnt_reg <= hcnt_next;
            if (e.fall)
                per_reg <= sat ? cnt_reg : cnt_inc; // hold 255, no wrap
            strobe <= strobe_next;
        end
    end

    property p_dce_rise;
        @(posedge clk) disable iff (reset)
        dce_en && e.fall |=> strobe;
    endproperty
    a_dce_rise: assert property (p_dce_rise) else $error("no strobe rise");

    property p_dce_width;
        @(posedge clk) disable iff (reset)
        dce_en && $rose(strobe) && $past(dce_en) |-> ##[1:255] !strobe || e.fall;
    endproperty
    a_dce_width: assert property (p_dce_width) else $error("strobe stuck");
endmodule
`default_nettype wire

/* File: verification/apo_capture_model.sv */
// downstream capture logic that latches words on the data-valid strobe
// assumes resolved pin levels, sampled in the system clock domain
`timescale 1ns/1ns
`default_nettype none
module apo_capture_model
    import apo_pkg::*;
(
    // clock
    input  wire logic                clk,
    // resolved pins
    input  wire logic [SAMPLE_W-1:0] word_pin,
    input  wire logic                flag_pin,
    input  wire logic                strobe_pin,
    // captured values
    output logic      [SAMPLE_W-1:0] cap_word,
    output logic                     cap_flag,
    output int                       cap_cnt
);
    logic strobe_q;

    // latch word and flag together on each strobe rising edge
    always @(posedge clk) begin
        strobe_q <= strobe_pin;
        if (strobe_pin && !strobe_q) begin
            cap_word <= word_pin;
            cap_flag <= flag_pin;
            cap_cnt  <= cap_cnt + 1;
        end
    end
endmodule
`default_nettype wire

/* File: verification/test_apo_adc_port.sv */
// self-checking bench for the adc parallel output port
// assumes apo_pkg, the design and the capture model are compiled first
`timescale 1ns/1ns
`default_nettype none
module test_apo_adc_port;
    import apo_pkg::*;
    logic                    clk = 1'b0;
    logic                    reset = 1'b1;
    logic [AW-1:0]           avs_address = '0;
    logic                    avs_read = 1'b0;
    logic                    avs_write = 1'b0;
    logic [31:0]             avs_writedata = '0;
    logic [31:0]             avs_readdata;
    logic [31:0]             q;
    logic                    avs_waitrequest;
    logic                    irq;
    logic                    clock_pos_in = 1'b0;
    logic                    clock_neg_in = 1'b1;
    logic                    neg_hi = 1'b0;
    logic                    odd = 1'b0;
    logic signed [ANA_W-1:0] analog_in = '0;
    logic [SAMPLE_W-1:0]     sample_word, word_pin, cap_word;
    logic [SAMPLE_W-1:0]     last_word = '0;
    logic                    sample_word_oe, out_of_range_flag;
    logic                    out_of_range_oe, sample_valid_strobe;
    logic                    sample_valid_oe, flag_pin, strobe_pin;
    logic                    cap_flag, last_flag = 1'b0, last_strobe = 1'b0;
    int                      cap_cnt, cc = 0, hi_cyc = 6;
    int                      n_errors = 0, cmp_count = 0;

    always #5 clk = ~clk;

    // converter clock: 12 and 13 cycle periods in turn, 125 ns average
    always @(posedge clk) begin
        cc <= (cc >= 11 + odd) ? 0 : cc + 1;
        if (cc >= 11 + odd) odd <= ~odd;
        clock_pos_in <= (cc < hi_cyc);
        clock_neg_in <= neg_hi | (cc >= hi_cyc);
    end

    // released pins show the inverse of the last driven level
    always @(posedge clk) begin
        if (sample_word_oe) last_word <= sample_word;
        if (out_of_range_oe) last_flag <= out_of_range_flag;
        if (sample_valid_oe) last_strobe <= sample_valid_strobe;
    end
    assign word_pin   = sample_word_oe ? sample_word : ~last_word;
    assign flag_pin   = out_of_range_oe ? out_of_range_flag : ~last_flag;
    assign strobe_pin = sample_valid_oe ? sample_valid_strobe : ~last_strobe;

    apo_adc_port #(.SETTLE_CYCLES(50)) dut_u (
        .clk(clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq),
        .clock_pos_in(clock_pos_in), .clock_neg_in(clock_neg_in),
        .analog_in(analog_in), .sample_word(sample_word),
        .sample_word_oe(sample_word_oe),
        .out_of_range_flag(out_of_range_flag),
        .out_of_range_oe(out_of_range_oe),
        .sample_valid_strobe(sample_valid_strobe),
        .sample_valid_oe(sample_valid_oe));

    apo_capture_model cap_u (
        .clk(clk), .word_pin(word_pin), .flag_pin(flag_pin),
        .strobe_pin(strobe_pin), .cap_word(cap_word),
        .cap_flag(cap_flag), .cap_cnt(cap_cnt));

    task automatic complete_run;
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_rng(input string what, input int lo, up, got);
        cmp_count++;
        if (got < lo || got > up) begin
            n_errors++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, up,
                     got);
        end
    endtask

    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [AW-1:0] a,
                       input logic [31:0] d, output logic [31:0] rd);
        int n;
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (n == 20) begin
            n_errors++;
            $display("MISMATCH bus answer expected waitrequest low seen none");
            complete_run();
        end
    endtask

    // expected flag and word: clamp, then optional gray via offset binary
    function automatic logic [12:0] expect_code(input int v, input logic g);
        logic [11:0] tc;
        logic [11:0] ob;
        tc = (v > 2047) ? 12'h7ff : (v < -2048) ? 12'h800 : v[11:0];
        ob = {~tc[11], tc[10:0]};
        return {(v > 2047 || v < -2048), g ? (ob ^ (ob >> 1)) : tc};
    endfunction

    task automatic t_reset;
        repeat (2) @(posedge clk);
        check("oe", 3'h7, {sample_word_oe, out_of_range_oe, sample_valid_oe});
        check("irq", 1'b0, irq);
        bus(1'b0, OFF_CTRL, 32'h0, q);
        check("ctrl reset", 32'h4, q);
        bus(1'b0, OFF_MASK, 32'h0, q);
        check("mask reset", 32'h0, q);
        bus(1'b1, 5'h14, 32'hffffffff, q);
        bus(1'b0, 5'h14, 32'h0, q);
        check("unmapped", 32'h0, q);
        repeat (60) @(posedge clk);
        bus(1'b0, OFF_STAT, 32'h0, q);
        check("settled event", 1'b1, q[S_SETTLED]);
        bus(1'b0, OFF_STAT, 32'h0, q);
        check("settled cleared", 1'b0, q[S_SETTLED]);
    endtask

    task automatic t_codes;
        int vals [7] = '{0, 5, -1, 2047, -2048, 2048, -2049};
        logic [12:0] e;
        for (int g = 0; g < 2; g++) begin
            bus(1'b1, OFF_CTRL, 32'h4 | (g << C_GRAY), q);
            foreach (vals[i]) begin
                analog_in <= vals[i][13:0];
                repeat (300) @(posedge clk);
                e = expect_code(vals[i], g[0]);
                check("word", e[11:0], cap_word);
                check("flag", e[12], cap_flag);
                bus(1'b0, OFF_DATA, 32'h0, q);
                check("data reg", e, q[12:0]);
            end
        end
        bus(1'b1, OFF_CTRL, 32'h4, q);
    endtask

    task automatic t_latency;
        int n;
        analog_in <= 14'sd100;
        repeat (300) @(posedge clk);
        for (n = 0; n < 30; n++) begin
            @(posedge clk);
            if (cc == hi_cyc) break;
        end
        analog_in <= 14'sd200; // reaches the sampler before this fall
        for (n = 0; n < 200; n++) begin
            @(posedge clk);
            if (sample_word === 12'h0c8) break;
        end
        check_rng("latency", 105, 112, n);
    endtask

    task automatic measure(output int w);
        int n;
        for (n = 0; n < 40 && sample_valid_strobe !== 1'b0; n++) @(posedge clk);
        for (n = 0; n < 40 && sample_valid_strobe !== 1'b1; n++) @(posedge clk);
        for (w = 0; w < 40 && sample_valid_strobe === 1'b1; w++) @(posedge clk);
    endtask

    task automatic t_strobe;
        int w;
        int hl [2] = '{3, 9};
        for (int d = 0; d < 2; d++) begin
            foreach (hl[k]) begin
                hi_cyc <= hl[k];
                bus(1'b1, OFF_CTRL, d ? 32'h4 : 32'h0, q);
                repeat (60) @(posedge clk);
                measure(w);
                if (d) check_rng("eq width", 5, 6, w);
                else check_rng("raw width", 12 - hl[k], 13 - hl[k], w);
            end
        end
        hi_cyc <= 6;
    endtask

    task automatic t_ctype;
        logic [31:0] c [3] = '{32'h4, 32'hc, 32'hc};
        logic nh [3] = '{1'b1, 1'b1, 1'b0};
        logic e [3] = '{1'b1, 1'b0, 1'b1};
        int n0;
        for (int k = 0; k < 3; k++) begin
            neg_hi <= nh[k];
            bus(1'b1, OFF_CTRL, c[k], q);
            repeat (40) @(posedge clk);
            n0 = cap_cnt;
            repeat (130) @(posedge clk);
            check("strobes", e[k], (cap_cnt - n0) >= 9);
        end
        neg_hi <= 1'b0;
        bus(1'b1, OFF_CTRL, 32'h4, q);
    endtask

    task automatic t_irq;
        bus(1'b1, OFF_MASK, 32'h2, q);
        bus(1'b0, OFF_STAT, 32'h0, q);
        repeat (150) @(posedge clk);
        check("irq in range", 1'b0, irq);
        analog_in <= 14'sd3000;
        repeat (150) @(posedge clk);
        check("irq over range", 1'b1, irq);
        bus(1'b0, OFF_STAT, 32'h0, q);
        check("status oor", 1'b1, q[S_OOR]);
        bus(1'b1, OFF_MASK, 32'h0, q);
        repeat (2) @(posedge clk);
        check("irq masked", 1'b0, irq);
        analog_in <= 14'sd0;
        bus(1'b1, OFF_MASK, 32'h1, q);
        repeat (30) @(posedge clk);
        check("irq sample", 1'b1, irq);
        bus(1'b1, OFF_MASK, 32'h0, q);
    endtask

    task automatic t_sleep;
        int n;
        bus(1'b1, OFF_CTRL, 32'h5, q);
        repeat (3) @(posedge clk);
        check("oe sleep", 3'h0, {sample_word_oe, out_of_range_oe,
              sample_valid_oe});
        bus(1'b0, OFF_DATA, 32'h0, q);
        check("settled sleep", 1'b0, q[D_SETTLED]);
        bus(1'b1, OFF_CTRL, 32'h4, q);
        repeat (3) @(posedge clk);
        check("oe awake", 3'h7, {sample_word_oe, out_of_range_oe,
              sample_valid_oe});
        for (n = 0; n < 40; n++) begin
            bus(1'b0, OFF_DATA, 32'h0, q);
            if (q[D_SETTLED] === 1'b1) break;
        end
        check_rng("settle polls", 8, 39, n);
        analog_in <= 14'sd7;
        repeat (300) @(posedge clk);
        check("word after wake", 12'h007, cap_word);
    endtask

    // reset for two cycles, then the scenarios in turn
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_codes();
        t_latency();
        t_strobe();
        t_ctype();
        t_irq();
        t_sleep();
        complete_run();
    end
endmodule
`default_nettype wire
